// ===== hdl/sgi_debounce.sv
// Per-pin debounce filter for the GPIO input path
`timescale 1ns/10ps
module sgi_debounce
  import sgi_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [PIN_N-1:0] raw,
  input wire logic [PIN_N-1:0] enable,
  output logic [PIN_N-1:0] filtered
);

  logic [PIN_N-1:0] out_r;

  assign filtered = out_r;

  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    logic [DB_CNT_W-1:0] cnt_r;
    logic [DB_CNT_W-1:0] cnt_nxt;
    logic out_nxt;
    logic differ;
    logic done;

    assign differ = raw[i] ^ out_r[i];
    assign done = differ && (cnt_r == DB_LAST);
    // Disabled pins follow the raw level so enabling later starts clean
    assign out_nxt = !enable[i] ? raw[i] : (done ? raw[i] : out_r[i]);
    // Any bounce back to the held level restarts the count
    assign cnt_nxt = (!enable[i] || !differ || done) ? '0
                     : cnt_r + DB_CNT_W'(1);

    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        cnt_r <= '0;
        out_r[i] <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        out_r[i] <= out_nxt;
      end
    end

    a_db_count: assert property (@(posedge clock) disable iff (reset)
      (enable[i] && $past(enable[i]) && out_r[i] != $past(out_r[i]))
      |-> $past(cnt_r) == DB_LAST)
      else $error("debounced level taken before the stable count");
  end

endmodule

// ===== hdl/sgi_input_path.sv
// GPIO input path: pin control, debounce enable and low input data
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module sgi_input_path
  import sgi_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic upstream_access,
  input wire logic [PIN_N-1:0] general_pin_n_in,
  output logic [PIN_N-1:0] general_pin_n_out,
  output logic [PIN_N-1:0] general_pin_n_oe_n,
  input wire logic [PIN_N-1:0] out_data,
  output logic irq_req
);

  // Registers
  logic [DATA_W-1:0] ctrl_low_r;
  logic [DATA_W-1:0] ctrl_high_r;
  logic [DATA_W-1:0] debounce_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [PIN_N-1:0] pin_out_r;
  logic [PIN_N-1:0] pin_oe_n_r;
  logic irq_r;

  // Pin synchroniser stages
  logic [PIN_N-1:0] sync1_r;
  logic [PIN_N-1:0] sync2_r;
  logic [PIN_N-1:0] sync3_r;
  logic [PIN_N-1:0] level_r;
  logic [PIN_N-1:0] level_nxt;
  logic [PIN_N-1:0] agree;

  // Decode
  logic hit_ctrl_low;
  logic hit_ctrl_high;
  logic hit_debounce;
  logic hit_level_low;
  logic wr_ctrl_low;
  logic wr_ctrl_high;
  logic wr_debounce;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] debounce_view;

  // Per-pin view of the control words
  logic [PIN_N-1:0] dir;
  logic [PIN_N-1:0] route;
  logic [PIN_N-1:0] is_input;
  logic [PIN_N-1:0] drive;
  logic [PIN_N-1:0] db_active;
  logic [PIN_N-1:0] filtered;
  logic [PIN_N-1:0] in_data;
  logic [PIN_N-1:0] irq_src;
  logic [DATA_W-1:0] level_low_word;

  assign hit_ctrl_low = (addr == OFF_CTRL_LOW);
  assign hit_ctrl_high = (addr == OFF_CTRL_HIGH);
  assign hit_debounce = (addr == OFF_DEBOUNCE);
  assign hit_level_low = (addr == OFF_LEVEL_LOW);

  assign wr_ctrl_low = wr_en && hit_ctrl_low;
  assign wr_ctrl_high = wr_en && hit_ctrl_high;
  // Debounce control lives only behind the upstream port
  assign wr_debounce = wr_en && hit_debounce && upstream_access;

  // Control words split into direction and routing per pin
  assign dir = {dir_of(ctrl_high_r), dir_of(ctrl_low_r)};
  assign route = {route_of(ctrl_high_r), route_of(ctrl_low_r)};
  assign is_input = ~dir;

  // Route value 1 on an output is reserved; the pin is left undriven
  assign drive = dir & ~route;

  // Debounce only acts on pins set as inputs
  assign db_active = debounce_r & is_input;

  // Output pins and interrupt-routed inputs read back as zero, data-routed input pins give their level
  assign in_data = filtered & is_input & ~route;
  assign level_low_word = {LEVEL_RSVD, in_data[HALF_N-1:0]};

  // Interrupt-routed inputs request on a high level
  assign irq_src = filtered & is_input & route;

  // Upstream-only register reads as zero from other ports
  assign debounce_view = upstream_access ? debounce_r : '0;

  // Input data is global: no port qualifier on this read
  assign rd_mux = hit_ctrl_low ? ctrl_low_r :
                  hit_ctrl_high ? ctrl_high_r :
                  hit_debounce ? debounce_view :
                  hit_level_low ? level_low_word : '0;

  // A change counts once the second and third stage agree
  assign agree = ~(sync2_r ^ sync3_r);
  assign level_nxt = (agree & sync3_r) | (~agree & level_r);

  assign rd_data = rd_data_r;
  assign general_pin_n_out = pin_out_r;
  assign general_pin_n_oe_n = pin_oe_n_r;
  assign irq_req = irq_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_low_r <= RST_CTRL;
      ctrl_high_r <= RST_CTRL;
    end else begin
      if (wr_ctrl_low) begin
        ctrl_low_r <= wr_data;
      end
      if (wr_ctrl_high) begin
        ctrl_high_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      debounce_r <= RST_DEBOUNCE;
    end else if (wr_debounce) begin
      debounce_r <= wr_data;
    end
  end

  // Writes to the input data offset are dropped: the word is read-only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_en ? rd_mux : '0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      level_r <= '0;
    end else begin
      sync1_r <= general_pin_n_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
    end
  end

  // Pins start undriven until software sets them as outputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
      irq_r <= 1'b0;
    end else begin
      pin_out_r <= out_data & drive;
      pin_oe_n_r <= ~drive;
      irq_r <= |irq_src;
    end
  end

  sgi_debounce u_debounce (
    .clock(clock),
    .reset(reset),
    .raw(level_r),
    .enable(db_active),
    .filtered(filtered)
  );

  // Helpers for the checks below
  logic rd_level_q;
  logic [HALF_N-1:0] dir_low_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_level_q <= 1'b0;
      dir_low_q <= '0;
    end else begin
      rd_level_q <= rd_en && hit_level_low;
      dir_low_q <= dir[HALF_N-1:0];
    end
  end

  a_out_reads_zero: assert property (
    @(posedge clock) disable iff (reset)
    rd_level_q |-> (rd_data[HALF_N-1:0] & dir_low_q) == '0)
    else $error("output pin read back non-zero");

  a_in_reads_level: assert property (
    @(posedge clock) disable iff (reset)
    rd_level_q |-> rd_data[HALF_N-1:0] == $past(in_data[HALF_N-1:0]))
    else $error("input data does not match pin level");

  a_rsvd_reads_zero: assert property (
    @(posedge clock) disable iff (reset)
    rd_level_q |-> rd_data[DATA_W-1:HALF_N] == '0)
    else $error("reserved input data bits not zero");

  a_dir_bit_map: assert property (
    @(posedge clock) disable iff (reset)
    rd_level_q |-> (rd_data[1:0] & {$past(ctrl_low_r[2+DIR_OFS]),
      $past(ctrl_low_r[DIR_OFS])}) == 2'b00)
    else $error("pin 0 or 1 not governed by its direction bit");

  a_pin31_ctrl: assert property (
    @(posedge clock) disable iff (reset)
    wr_ctrl_high |=> dir[PIN_N-1] == $past(wr_data[P31_DIR_BIT])
      && route[PIN_N-1] == $past(wr_data[P31_ROUTE_BIT])
      && dir[PIN_N-2] == $past(wr_data[P30_DIR_BIT])
      && route[PIN_N-2] == $past(wr_data[P30_ROUTE_BIT]))
    else $error("pin 30 or 31 control bits not stored");

  a_db_port_gate: assert property (
    @(posedge clock) disable iff (reset)
    (wr_en && hit_debounce && !upstream_access) |=> $stable(debounce_r))
    else $error("debounce control written from a non-upstream port");

  a_irq_route: assert property (
    @(posedge clock) disable iff (reset)
    irq_req == $past(|(filtered & ~dir & route)))
    else $error("interrupt request does not follow routed inputs");

  a_pin_drive: assert property (
    @(posedge clock) disable iff (reset)
    ##1 general_pin_n_oe_n == ~$past(dir & ~route)
      && (general_pin_n_out & general_pin_n_oe_n) == '0)
    else $error("pin drive does not follow direction and route");

  a_db_filter: assert property (
    @(posedge clock) disable iff (reset)
    ((filtered ^ $past(filtered)) & $past(db_active)
      & ($past(level_r) ^ $past(level_r, 2))) == '0)
    else $error("debounced pin changed while its level was moving");

  a_sync_agree: assert property (
    @(posedge clock) disable iff (reset)
    ((level_r ^ $past(level_r)) & ~$past(agree)) == '0)
    else $error("pin level taken before sync stages agreed");

  c_read_input: cover property (@(posedge clock) disable iff (reset)
    rd_level_q && rd_data[HALF_N-1:0] != '0);

  c_irq_raise: cover property (@(posedge clock) disable iff (reset)
    $rose(irq_req));

  c_pin_driven: cover property (@(posedge clock) disable iff (reset)
    general_pin_n_oe_n[PIN_N-1] == 1'b0);

  c_db_accept: cover property (@(posedge clock) disable iff (reset)
    (db_active[0] && $past(db_active[0]) && $changed(filtered[0])));

endmodule

// ===== hdl/sgi_pkg.sv
// Constants and helper functions for the switch GPIO input path
// Notes on behaviour
// - Pins 30/31 route and direction bits, reset 0
// - Input pin routes to data or interrupt
// - Output pin driven from output data bit
// - Debounce enable per pin, inputs only, reset 0
// - Input data bit reads 0 for outputs
// - Input data bit shows pin level for inputs routed to data; interrupt-routed inputs read 0
// - Pin n uses lower direction bit 2n+1
// - Low input data read-only, upper bits zero
// - Debounce upstream only, input data global
package sgi_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_N = 32;
  localparam int HALF_N = 16;

  // Register offsets in the switch configuration space
  localparam logic [ADDR_W-1:0] OFF_CTRL_LOW = 12'h62c;
  localparam logic [ADDR_W-1:0] OFF_CTRL_HIGH = 12'h630;
  localparam logic [ADDR_W-1:0] OFF_DEBOUNCE = 12'h638;
  localparam logic [ADDR_W-1:0] OFF_LEVEL_LOW = 12'h63c;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CTRL = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_DEBOUNCE = 32'h0000_0000;
  localparam logic [HALF_N-1:0] LEVEL_RSVD = 16'h0000;

  // Field layout: pin n of a half uses bit 2n (route) and 2n+1 (direction)
  localparam int ROUTE_OFS = 0;
  localparam int DIR_OFS = 1;
  localparam int P30_ROUTE_BIT = 28;
  localparam int P30_DIR_BIT = 29;
  localparam int P31_ROUTE_BIT = 30;
  localparam int P31_DIR_BIT = 31;

  // Debounce timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int DB_TIME_NS = 1000;
  localparam int DB_CYCLES = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_CNT_W = 5;
  localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(DB_CYCLES - 1);

  // Pick the direction bits (odd) of one half's control word
  function automatic logic [HALF_N-1:0] dir_of(input logic [DATA_W-1:0] c);
    logic [HALF_N-1:0] d;
    d = '0;
    for (int n = 0; n < HALF_N; n++) begin
      d[n] = c[2*n+DIR_OFS];
    end
    return d;
  endfunction

  // Pick the routing bits (even) of one half's control word
  function automatic logic [HALF_N-1:0] route_of(input logic [DATA_W-1:0] c);
    logic [HALF_N-1:0] r;
    r = '0;
    for (int n = 0; n < HALF_N; n++) begin
      r[n] = c[2*n+ROUTE_OFS];
    end
    return r;
  endfunction

endpackage

// ===== tb/sgi_board_model.sv
// Board-side model of the general purpose pins
`timescale 1ns/10ps
module sgi_board_model
  import sgi_pkg::*;
(
  input wire logic [PIN_N-1:0] board_level,
  input wire logic [PIN_N-1:0] pin_out,
  input wire logic [PIN_N-1:0] pin_oe_n,
  output logic [PIN_N-1:0] pin_wire
);
  // A driven pin shows the switch's value, an undriven one the board's
  assign pin_wire = (~pin_oe_n & pin_out) | (pin_oe_n & board_level);
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the GPIO input path
`timescale 1ns/10ps
module testbench
  import sgi_pkg::*;
();
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic [PIN_N-1:0] out_data = '0;
  logic [PIN_N-1:0] board = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic up = 1'b1;
  logic [DATA_W-1:0] rd_data;
  logic [PIN_N-1:0] pin_in, pin_out, oe_n;
  logic irq;
  logic [31:0] c_lo = '0;
  logic [31:0] c_hi = '0;
  logic [31:0] v;
  int err_count = 0;
  int checks = 0;

  always #20 clock = ~clock;

  sgi_input_path dut (.clock(clock), .reset(reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .upstream_access(up), .general_pin_n_in(pin_in),
    .general_pin_n_out(pin_out), .general_pin_n_oe_n(oe_n),
    .out_data(out_data), .irq_req(irq));

  sgi_board_model board_i (.board_level(board), .pin_out(pin_out),
    .pin_oe_n(oe_n), .pin_wire(pin_in));

  // Kind 0: driven output, 1: readable input, 2: interrupt input
  function automatic logic [31:0] mask(input int k);
    logic [31:0] m;
    logic d, r;
    m = '0;
    for (int n = 0; n < 32; n++) begin
      d = (n < 16) ? c_lo[2*n+1] : c_hi[2*(n-16)+1];
      r = (n < 16) ? c_lo[2*n] : c_hi[2*(n-16)];
      m[n] = (k == 0) ? (d & ~r) : (k == 1) ? (~d & ~r) : (~d & r);
    end
    return m;
  endfunction

  // Software must never pick route 1 on an output, so clear those
  function automatic logic [31:0] legal(input logic [31:0] c);
    return c & ~((c & 32'haaaa_aaaa) >> 1);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    // Data still stands here: the clear lands after this edge
    @(posedge clock);
    v = rd_data;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic verify_all();
    rd(OFF_LEVEL_LOW);
    check(v, {16'h0000, board[15:0]} & mask(1));
    check(oe_n, ~mask(0));
    check(pin_out, out_data & mask(0));
    check({31'h0, irq}, {31'h0, |(board & mask(2))});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    complete_run();
  end

  initial begin
    void'($urandom(44));
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_DEBOUNCE);
    check(v, RST_DEBOUNCE);
    rd(OFF_CTRL_HIGH);
    check(v, RST_CTRL);
    rd(12'h700);
    check(v, 32'h0000_0000);
    wr(OFF_LEVEL_LOW, 32'hffff_ffff);
    settle(8);
    verify_all();
    $display("reset and read-only test done");
    for (int i = 0; i < 8; i++) begin
      board <= $urandom();
      out_data <= $urandom();
      c_lo = legal($urandom());
      c_hi = legal($urandom());
      wr(OFF_CTRL_LOW, c_lo);
      wr(OFF_CTRL_HIGH, c_hi);
      rd(OFF_CTRL_HIGH);
      check(v, c_hi);
      settle(8);
      verify_all();
    end
    $display("random direction test done");
    c_lo = '0;
    c_hi = 32'h6000_0000;
    wr(OFF_CTRL_LOW, c_lo);
    wr(OFF_CTRL_HIGH, c_hi);
    for (int i = 0; i < 2; i++) begin
      board[31] <= ~i[0];
      board[30] <= i[0];
      settle(8);
      verify_all();
    end
    $display("pin 30 and 31 test done");
    up <= 1'b0;
    wr(OFF_DEBOUNCE, 32'h0000_0001);
    rd(OFF_DEBOUNCE);
    check(v, 32'h0000_0000);
    up <= 1'b1;
    rd(OFF_DEBOUNCE);
    check(v, 32'h0000_0000);
    wr(OFF_DEBOUNCE, 32'h0000_0001);
    rd(OFF_DEBOUNCE);
    check(v, 32'h0000_0001);
    board <= '0;
    settle(40);
    board[0] <= 1'b1;
    settle(12);
    // Too short to pass the filter yet, an unfiltered pin shows by now
    rd(OFF_LEVEL_LOW);
    check(v, 32'h0000_0000);
    settle(30);
    verify_all();
    wr(OFF_DEBOUNCE, 32'h0000_0000);
    board[0] <= 1'b0;
    settle(8);
    verify_all();
    $display("debounce test done");
    complete_run();
  end
endmodule
